// >>> hw/split_reload_capture_timer.sv
`timescale 1ns/1ns
`include "tmr_defines.svh"

module split_reload_capture_timer (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [3:0] sfr_page,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic usb_sof,
  input wire logic slow_osc,
  input wire logic ext_osc,
  input wire logic t3_int_enable,
  input wire logic t4_int_enable,
  output logic [7:0] sfr_rdata,
  output logic t3_irq,
  output logic t4_irq
);

  localparam int NUM_TIMERS = 2;

  logic [3:0] sys_div_q;
  logic tick_sys_q;
  logic [2:0] ext_div_q;
  logic tick_ext_q;
  logic ext_meta_q;
  logic ext_sync_q;
  logic ext_prev_q;
  logic ext_rise;
  logic slow_meta_q;
  logic slow_sync_q;
  logic slow_prev_q;
  logic slow_fall;
  logic t3_capture_event;
  logic [7:0] rdata_q;
  logic [NUM_TIMERS-1:0] irq_q;
  logic [NUM_TIMERS-1:0] int_enable;
  logic [NUM_TIMERS-1:0] page_hit;
  logic [NUM_TIMERS-1:0] tick;
  logic [NUM_TIMERS-1:0] low_wrap;
  logic [NUM_TIMERS-1:0] high_wrap;
  logic [NUM_TIMERS-1:0] cap_fire;
  logic [NUM_TIMERS-1:0] irq_d;
  logic [7:0] rdata_sel [NUM_TIMERS];
  tmr_pkg::timer_wr_t wr [NUM_TIMERS];
  tmr_pkg::timer_ctrl_t ctrl [NUM_TIMERS];
  logic [7:0] reload_low [NUM_TIMERS];
  logic [7:0] reload_high [NUM_TIMERS];
  logic [7:0] count_low [NUM_TIMERS];
  logic [7:0] count_high [NUM_TIMERS];
  logic [7:0] rdata_d;
  logic rd_hit;

  ////////////////////////////////////////////////////////////////////////////
  // system clock divide by twelve
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sys_div_q <= `SYS_DIV_ZERO;
      tick_sys_q <= 1'b0;
    end else begin
      sys_div_q <= (sys_div_q == `SYS_DIV_LAST) ? `SYS_DIV_ZERO : sys_div_q + `SYS_DIV_ONE;
      tick_sys_q <= sys_div_q == `SYS_DIV_LAST;
    end
  end

  // oscillator must stay below half of mclk or edges are lost
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ext_meta_q <= 1'b0;
      ext_sync_q <= 1'b0;
      ext_prev_q <= 1'b0;
    end else begin
      ext_meta_q <= ext_osc;
      ext_sync_q <= ext_meta_q;
      ext_prev_q <= ext_sync_q;
    end
  end

  assign ext_rise = ext_sync_q & ~ext_prev_q;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ext_div_q <= `EXT_DIV_ZERO;
      tick_ext_q <= 1'b0;
    end else begin
      if (ext_rise) begin
        ext_div_q <= ext_div_q + `EXT_DIV_ONE;
      end
      tick_ext_q <= ext_rise & (ext_div_q == `EXT_DIV_LAST);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // slow oscillator is asynchronous; sof is already an mclk pulse
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      slow_meta_q <= 1'b0;
      slow_sync_q <= 1'b0;
      slow_prev_q <= 1'b0;
    end else begin
      slow_meta_q <= slow_osc;
      slow_sync_q <= slow_meta_q;
      slow_prev_q <= slow_sync_q;
    end
  end

  assign slow_fall = ~slow_sync_q & slow_prev_q;

  assign t3_capture_event =
    (ctrl[0].capture_source_select == tmr_pkg::capture_on_slow_osc_edge) ? slow_fall : usb_sof;

  ////////////////////////////////////////////////////////////////////////////
  assign int_enable = {t4_int_enable, t3_int_enable};
  assign rd_hit = |page_hit & sfr_rd;

  generate
    for (genvar i = 0; i < NUM_TIMERS; i++) begin : g_timer
      assign page_hit[i] = sfr_page == ((i == 0) ? `TMR3_PAGE : `TMR4_PAGE);
      assign wr[i].ctrl = sfr_wr & page_hit[i] & (sfr_addr == `TMR_CTRL_ADDR);
      assign wr[i].reload_low = sfr_wr & page_hit[i] & (sfr_addr == `TMR_RELOAD_LOW_ADDR);
      assign wr[i].reload_high = sfr_wr & page_hit[i] & (sfr_addr == `TMR_RELOAD_HIGH_ADDR);
      assign wr[i].count_low = sfr_wr & page_hit[i] & (sfr_addr == `TMR_COUNT_LOW_ADDR);
      assign wr[i].count_high = sfr_wr & page_hit[i] & (sfr_addr == `TMR_COUNT_HIGH_ADDR);

      timer_core #(
        .HAS_CAPTURE(i == 0),
        .RSVD_MASK((i == 0) ? `TMR_NO_RSVD_MASK : `TMR4_RSVD_MASK)
      ) u_core (
        .mclk(mclk),
        .rst_n(rst_n),
        .tick_sys(tick_sys_q),
        .tick_ext(tick_ext_q),
        .wr(wr[i]),
        .wdata(sfr_wdata),
        .capture_event((i == 0) ? t3_capture_event : 1'b0),
        .ctrl_q(ctrl[i]),
        .reload_low_q(reload_low[i]),
        .reload_high_q(reload_high[i]),
        .count_low_q(count_low[i]),
        .count_high_q(count_high[i]),
        .tick(tick[i]),
        .low_wrap(low_wrap[i]),
        .high_wrap(high_wrap[i]),
        .cap_fire(cap_fire[i])
      );

      assign rdata_sel[i] =
        (sfr_addr == `TMR_CTRL_ADDR) ? ctrl[i] :
        (sfr_addr == `TMR_RELOAD_LOW_ADDR) ? reload_low[i] :
        (sfr_addr == `TMR_RELOAD_HIGH_ADDR) ? reload_high[i] :
        (sfr_addr == `TMR_COUNT_LOW_ADDR) ? count_low[i] :
        (sfr_addr == `TMR_COUNT_HIGH_ADDR) ? count_high[i] : `TMR_REG_RESET;

      assign irq_d[i] = int_enable[i] &
        (ctrl[i].ovf_high | (ctrl[i].ovf_low & ctrl[i].low_irq_enable));
    end
  endgenerate

  assign rdata_d = page_hit[0] ? rdata_sel[0] : (page_hit[1] ? rdata_sel[1] : `TMR_REG_RESET);

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= `TMR_REG_RESET;
      irq_q <= '0;
    end else begin
      if (rd_hit) begin
        rdata_q <= rdata_d;
      end
      irq_q <= irq_d;
    end
  end

  assign sfr_rdata = rdata_q;
  assign t3_irq = irq_q[0];
  assign t4_irq = irq_q[1];

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  sequence seq_sys_gap;
    (!tick_sys_q) [*8] ##1 (!tick_sys_q) [*3];
  endsequence

  sequence seq_capture_then_copy;
    cap_fire[0] && !wr[0].count_low && !wr[0].count_high
      ##1 reload_low[0] == $past(count_low[0]) && reload_high[0] == $past(count_high[0]);
  endsequence

  chk_low_flag_set: assert property (
    low_wrap[0] |=> ctrl[0].ovf_low)
    else $error("low overflow did not set low flag");

  chk_high_flag_set: assert property (
    high_wrap[1] && !ctrl[1].split_mode |=> ctrl[1].ovf_high)
    else $error("16-bit wrap did not set high flag");

  chk_low_irq_gate: assert property (
    ctrl[0].ovf_low && !ctrl[0].low_irq_enable && !ctrl[0].ovf_high |=> !t3_irq)
    else $error("low overflow interrupted while disabled");

  chk_carry_16bit: assert property (
    tick[0] && ctrl[0].run && !ctrl[0].split_mode && count_low[0] != `TMR_CNT_MAX
      && !wr[0].count_high |=> $stable(count_high[0]))
    else $error("high byte moved without carry");

  chk_split_low_runs: assert property (
    tick[0] && ctrl[0].split_mode && !ctrl[0].run && count_low[0] != `TMR_CNT_MAX
      && !wr[0].count_low |=> count_low[0] == $past(count_low[0]) + `TMR_CNT_ONE)
    else $error("split low byte stopped with run clear");

  chk_sys_div_twelve: assert property (
    tick_sys_q |=> seq_sys_gap ##1 tick_sys_q)
    else $error("system tick spacing not twelve");

  chk_ext_div_eight: assert property (
    tick_ext_q |-> ext_div_q == `EXT_DIV_ZERO && $past(ext_rise))
    else $error("external tick not on eighth edge");

  chk_reload_split: assert property (
    low_wrap[0] && ctrl[0].split_mode && !wr[0].count_low
      |=> count_low[0] == $past(reload_low[0]))
    else $error("split low byte did not reload");

  chk_capture_copy: assert property (
    cap_fire[0] && !wr[0].count_low && !wr[0].count_high |-> seq_capture_then_copy)
    else $error("capture did not copy count");

  chk_capture_source: assert property (
    ctrl[0].capture_enable && ctrl[0].capture_source_select && usb_sof && !slow_fall
      |-> !cap_fire[0])
    else $error("sof captured while slow edge selected");

  chk_count_write: assert property (
    wr[0].count_low |=> count_low[0] == $past(sfr_wdata))
    else $error("count low write lost");

  chk_t4_reserved: assert property (
    1'b1 |-> !ctrl[1].capture_enable && !ctrl[1].capture_source_select)
    else $error("timer 4 reserved bits not zero");

  chk_read_high: assert property (
    rd_hit && page_hit[0] && sfr_addr == `TMR_COUNT_HIGH_ADDR |=> sfr_rdata == $past(count_high[0]))
    else $error("high count read mismatch");

endmodule : split_reload_capture_timer

// >>> include/tmr_defines.svh
`ifndef TMR_DEFINES_SVH
`define TMR_DEFINES_SVH

// register offsets, shared by both timers; the page picks the timer
`define TMR_CTRL_ADDR 8'h91
`define TMR_RELOAD_LOW_ADDR 8'h92
`define TMR_RELOAD_HIGH_ADDR 8'h93
`define TMR_COUNT_LOW_ADDR 8'h94
`define TMR_COUNT_HIGH_ADDR 8'h95
`define TMR3_PAGE 4'h0
`define TMR4_PAGE 4'hf

`define TMR_REG_RESET 8'h00
`define TMR_CNT_MAX 8'hff
`define TMR_CNT_ONE 8'h01
// timer 4 control bits 4 and 1 are reserved, read as zero
`define TMR4_RSVD_MASK 8'h12
`define TMR_NO_RSVD_MASK 8'h00

`define SYS_DIV_TWELVE 4'hc
`define SYS_DIV_LAST 4'hb
`define SYS_DIV_ZERO 4'h0
`define SYS_DIV_ONE 4'h1
`define EXT_DIV_LAST 3'h7
`define EXT_DIV_ZERO 3'h0
`define EXT_DIV_ONE 3'h1

`endif

// >>> include/tmr_pkg.sv
package tmr_pkg;

  typedef struct packed {
    logic ovf_high;
    logic ovf_low;
    logic low_irq_enable;
    logic capture_enable;
    logic split_mode;
    logic run;
    logic capture_source_select;
    logic external_clock_select;
  } timer_ctrl_t;

  typedef struct packed {
    logic ctrl;
    logic reload_low;
    logic reload_high;
    logic count_low;
    logic count_high;
  } timer_wr_t;

  typedef enum logic {
    usb_sof_capture = 1'b0,
    capture_on_slow_osc_edge = 1'b1
  } capture_src_t;

  typedef enum logic {
    sys_clock_div_twelve = 1'b0,
    ext_osc_div_eight = 1'b1
  } clock_src_t;

endpackage : tmr_pkg

// >>> hw/timer_core.sv
`timescale 1ns/1ns
`include "tmr_defines.svh"

module timer_core #(
  parameter bit HAS_CAPTURE = 1'b1,
  parameter logic [7:0] RSVD_MASK = `TMR_NO_RSVD_MASK
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic tick_sys,
  input wire logic tick_ext,
  input wire tmr_pkg::timer_wr_t wr,
  input wire logic [7:0] wdata,
  input wire logic capture_event,
  output tmr_pkg::timer_ctrl_t ctrl_q,
  output logic [7:0] reload_low_q,
  output logic [7:0] reload_high_q,
  output logic [7:0] count_low_q,
  output logic [7:0] count_high_q,
  output logic tick,
  output logic low_wrap,
  output logic high_wrap,
  output logic cap_fire
);

  tmr_pkg::timer_ctrl_t ctrl_d;
  logic [7:0] reload_low_d;
  logic [7:0] reload_high_d;
  logic [7:0] count_low_d;
  logic [7:0] count_high_d;
  logic low_step;
  logic high_step;
  logic low_at_max;
  logic high_at_max;
  logic full_wrap;

  ////////////////////////////////////////////////////////////////////////////
  // tick source pick
  assign tick = (ctrl_q.external_clock_select == tmr_pkg::ext_osc_div_eight) ? tick_ext : tick_sys;
  assign low_at_max = count_low_q == `TMR_CNT_MAX;
  assign high_at_max = count_high_q == `TMR_CNT_MAX;
  assign low_step = tick & (ctrl_q.split_mode | ctrl_q.run);
  assign high_step = tick & ctrl_q.run & (ctrl_q.split_mode | low_at_max);
  assign low_wrap = low_step & low_at_max;
  assign high_wrap = high_step & high_at_max;
  assign full_wrap = high_wrap & ~ctrl_q.split_mode;
  assign cap_fire = HAS_CAPTURE & ctrl_q.capture_enable & capture_event;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    ctrl_d = ctrl_q;
    if (wr.ctrl) begin
      ctrl_d = tmr_pkg::timer_ctrl_t'(wdata & ~RSVD_MASK);
    end
    ctrl_d.ovf_low = ctrl_d.ovf_low | low_wrap;
    ctrl_d.ovf_high = ctrl_d.ovf_high | high_wrap | cap_fire;
  end

  always_comb begin
    count_low_d = count_low_q;
    if (wr.count_low) begin
      count_low_d = wdata;
    end else if (low_wrap) begin
      count_low_d = (ctrl_q.split_mode | full_wrap) ? reload_low_q : `TMR_REG_RESET;
    end else if (low_step) begin
      count_low_d = count_low_q + `TMR_CNT_ONE;
    end
  end

  always_comb begin
    count_high_d = count_high_q;
    if (wr.count_high) begin
      count_high_d = wdata;
    end else if (high_wrap) begin
      count_high_d = reload_high_q;
    end else if (high_step) begin
      count_high_d = count_high_q + `TMR_CNT_ONE;
    end
  end

  assign reload_low_d = cap_fire ? count_low_q : (wr.reload_low ? wdata : reload_low_q);
  assign reload_high_d = cap_fire ? count_high_q : (wr.reload_high ? wdata : reload_high_q);

  ////////////////////////////////////////////////////////////////////////////
  // all zero at reset
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= tmr_pkg::timer_ctrl_t'(`TMR_REG_RESET);
      reload_low_q <= `TMR_REG_RESET;
      reload_high_q <= `TMR_REG_RESET;
      count_low_q <= `TMR_REG_RESET;
      count_high_q <= `TMR_REG_RESET;
    end else begin
      ctrl_q <= ctrl_d;
      reload_low_q <= reload_low_d;
      reload_high_q <= reload_high_d;
      count_low_q <= count_low_d;
      count_high_q <= count_high_d;
    end
  end

endmodule : timer_core

// >>> tb/split_reload_capture_timer_test.sv
`timescale 1ns/1ns
`include "tmr_defines.svh"

module split_reload_capture_timer_test;
  logic mclk, rst_n, sfr_wr, sfr_rd, usb_sof, slow_osc, ext_osc;
  logic t3_int_enable, t4_int_enable, t3_irq, t4_irq;
  logic [3:0] sfr_page;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, v, v2;
  logic [3:0] pages [2] = '{`TMR3_PAGE, `TMR4_PAGE};
  int failures, checks_done, seed, r;
  int m_cl, m_ch, m_fl, m_fh, m_rl, m_rh;
  tmr_pkg::timer_ctrl_t c;

  split_reload_capture_timer dut_u (
    .mclk, .rst_n, .sfr_page, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata,
    .usb_sof, .slow_osc, .ext_osc, .t3_int_enable, .t4_int_enable,
    .sfr_rdata, .t3_irq, .t4_irq
  );

  always #5 mclk = ~mclk;
  // even half period never lands on a rising mclk edge, so no sampling race
  always #16 ext_osc = ~ext_osc;

  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : give_verdict

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic reg_wr(input logic [3:0] pg, input logic [7:0] a, input logic [7:0] d);
    sfr_page <= pg;
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge mclk);
    sfr_wr <= 1'b0;
    @(posedge mclk);
  endtask : reg_wr

  task automatic reg_rd(input logic [3:0] pg, input logic [7:0] a, output logic [7:0] d);
    sfr_page <= pg;
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge mclk);
    sfr_rd <= 1'b0;
    #1;
    d = sfr_rdata;
    @(posedge mclk);
  endtask : reg_rd

  task automatic irq_check(input string what, input bit t4, input logic exp);
    repeat (3) @(posedge mclk);
    #1;
    check(what, {7'h0, exp}, {7'h0, t4 ? t4_irq : t3_irq});
    @(posedge mclk);
  endtask : irq_check

  ////////////////////////////////////////////////////////////////////////////
  // reference counter, one call step per timer tick
  task automatic model_ticks(input int n, input bit split, input bit hi_run);
    for (int i = 0; i < n; i++) begin
      if (split || hi_run) begin
        m_cl = m_cl + 1;
      end
      if (m_cl == 256) begin
        m_cl = split ? m_rl : 0;
        m_fl = 1;
        if (!split) begin
          m_ch = m_ch + 1;
        end
      end
      if (split && hi_run) begin
        m_ch = m_ch + 1;
      end
      if (m_ch == 256) begin
        m_ch = m_rh;
        m_cl = split ? m_cl : m_rl;
        m_fh = 1;
      end
    end
  endtask : model_ticks

  task automatic load(input logic [3:0] pg, input int rl, rh, cl, ch);
    m_rl = rl;
    m_rh = rh;
    m_cl = cl;
    m_ch = ch;
    m_fl = 0;
    m_fh = 0;
    reg_wr(pg, `TMR_CTRL_ADDR, 8'h00);
    reg_wr(pg, `TMR_RELOAD_LOW_ADDR, rl[7:0]);
    reg_wr(pg, `TMR_RELOAD_HIGH_ADDR, rh[7:0]);
    reg_wr(pg, `TMR_COUNT_LOW_ADDR, cl[7:0]);
    reg_wr(pg, `TMR_COUNT_HIGH_ADDR, ch[7:0]);
  endtask : load

  // run on and off exactly 12*k edges apart gives exactly k ticks;
  // control read just before stop, rewritten so flags survive
  task automatic run_window(input logic [3:0] pg, input tmr_pkg::timer_ctrl_t cfg, input int k);
    cfg.run = 1'b1;
    reg_wr(pg, `TMR_CTRL_ADDR, cfg);
    repeat (12 * k - 4) @(posedge mclk);
    reg_rd(pg, `TMR_CTRL_ADDR, v);
    v2 = v;
    v2[2] = 1'b0;
    reg_wr(pg, `TMR_CTRL_ADDR, v2);
    model_ticks(k, cfg.split_mode, 1'b1);
  endtask : run_window

  task automatic check_counts(input logic [3:0] pg, input bit lo);
    reg_rd(pg, `TMR_COUNT_HIGH_ADDR, v);
    check("count_high", m_ch[7:0], v);
    reg_rd(pg, `TMR_RELOAD_HIGH_ADDR, v);
    check("reload_high", m_rh[7:0], v);
    if (lo) begin
      reg_rd(pg, `TMR_COUNT_LOW_ADDR, v);
      check("count_low", m_cl[7:0], v);
    end
  endtask : check_counts

  task automatic event_pulse(input bit slow);
    if (slow) begin
      slow_osc <= 1'b0;
      repeat (2) @(posedge mclk);
      slow_osc <= 1'b1;
    end else begin
      usb_sof <= 1'b1;
      @(posedge mclk);
      usb_sof <= 1'b0;
    end
    repeat (6) @(posedge mclk);
  endtask : event_pulse

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #500_000;
    failures++;
    give_verdict();
  end

  initial begin
    mclk = 1'b0;
    ext_osc = 1'b0;
    rst_n = 1'b0;
    sfr_page = 4'h0;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    usb_sof = 1'b0;
    slow_osc = 1'b1;
    t3_int_enable = 1'b1;
    t4_int_enable = 1'b1;
    seed = 32'hd1f7b8f7;
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    foreach (pages[p]) for (int a = 8'h91; a <= 8'h96; a++) begin
      reg_rd(pages[p], a[7:0], v);
      check("reset_value", 8'h00, v);
    end
    foreach (pages[p]) for (int a = 8'h92; a <= 8'h95; a++) begin
      r = $random(seed);
      reg_wr(pages[p], a[7:0], r[7:0]);
      reg_rd(pages[p], a[7:0], v);
      check("read_back", r[7:0], v);
    end
    reg_wr(`TMR4_PAGE, `TMR_CTRL_ADDR, 8'h12);
    reg_rd(`TMR4_PAGE, `TMR_CTRL_ADDR, v);
    check("t4_control", 8'h00, v);
    reg_wr(`TMR3_PAGE, `TMR_CTRL_ADDR, 8'h12);
    reg_rd(`TMR3_PAGE, `TMR_CTRL_ADDR, v);
    check("t3_control", 8'h12, v);
    foreach (pages[p]) begin
      r = {$random(seed)} % 241;
      load(pages[p], r, 8'hff, 8'hfd, 8'hff);
      c = '0;
      run_window(pages[p], c, 5);
      c.run = 1'b1;
      c.ovf_high = m_fh[0];
      c.ovf_low = m_fl[0];
      check("control", c, v);
      check_counts(pages[p], 1'b1);
      irq_check("wrap_irq", p != 0, 1'b1);
    end
    r = {$random(seed)} % 241;
    load(`TMR3_PAGE, 8'h00, r, 8'hf8, 8'hfe);
    c = '0;
    c.split_mode = 1'b1;
    run_window(`TMR3_PAGE, c, 3);
    check("split_high_flag", 8'h01, {7'h0, v[7]});
    check_counts(`TMR3_PAGE, 1'b0);
    reg_rd(`TMR3_PAGE, `TMR_COUNT_LOW_ADDR, v);
    m_cl = v;
    repeat (118) @(posedge mclk);
    reg_rd(`TMR3_PAGE, `TMR_COUNT_LOW_ADDR, v);
    model_ticks(10, 1'b1, 1'b0);
    check("split_low", m_cl[7:0], v);
    c.ovf_low = 1'b1;
    reg_wr(`TMR3_PAGE, `TMR_CTRL_ADDR, c);
    irq_check("low_irq_masked", 1'b0, 1'b0);
    c.low_irq_enable = 1'b1;
    reg_wr(`TMR3_PAGE, `TMR_CTRL_ADDR, c);
    irq_check("low_irq", 1'b0, 1'b1);
    t3_int_enable <= 1'b0;
    irq_check("low_irq_global_off", 1'b0, 1'b0);
    t3_int_enable <= 1'b1;
    for (int s = 0; s < 2; s++) begin
      r = $random(seed);
      load(`TMR3_PAGE, 0, 0, r[7:0], r[15:8]);
      c = '0;
      c.capture_enable = 1'b1;
      c.capture_source_select = s[0];
      reg_wr(`TMR3_PAGE, `TMR_CTRL_ADDR, c);
      event_pulse(s == 0);
      reg_rd(`TMR3_PAGE, `TMR_RELOAD_LOW_ADDR, v);
      check("no_capture", 8'h00, v);
      event_pulse(s != 0);
      reg_rd(`TMR3_PAGE, `TMR_RELOAD_LOW_ADDR, v);
      check("capture_low", r[7:0], v);
      reg_rd(`TMR3_PAGE, `TMR_RELOAD_HIGH_ADDR, v);
      check("capture_high", r[15:8], v);
      irq_check("capture_irq", 1'b0, 1'b1);
    end
    // external rate, synchroniser jitter allows one tick
    load(`TMR4_PAGE, 0, 0, 0, 0);
    c = '0;
    c.run = 1'b1;
    c.external_clock_select = 1'b1;
    reg_wr(`TMR4_PAGE, `TMR_CTRL_ADDR, c);
    reg_rd(`TMR4_PAGE, `TMR_COUNT_LOW_ADDR, v2);
    repeat (270) @(posedge mclk);
    reg_rd(`TMR4_PAGE, `TMR_COUNT_LOW_ADDR, v);
    r = v - v2;
    check("ext_rate", 8'h01, {7'h0, r >= 9 && r <= 11});
    reg_wr(`TMR4_PAGE, `TMR_CTRL_ADDR, 8'h00);
    give_verdict();
  end
endmodule : split_reload_capture_timer_test
